// file: cbsc_cfg_if.sv
// Carries the stored configuration fields from the register bank to the pins.
`timescale 1ns/1ps
interface cbsc_cfg_if;
   logic [cbsc_pkg::CFG_W-1:0] cfg;
   modport src (output cfg);
   modport dst (input cfg);
endinterface // cbsc_cfg_if

// file: cbsc_pin_ctl.sv
// Turns the configuration fields into registered pin and control outputs.
`timescale 1ns/1ps
module cbsc_pin_ctl (
   input  wire logic       mclk,
   input  wire logic       rst_n,
   cbsc_cfg_if.dst         cfg_if,
   input  wire logic       card32_present,
   input  wire logic       card16_present,
   input  wire logic       card_idle,
   input  wire logic       card_clk_stopped,
   input  wire logic       card_card_dma_request_line,
   input  wire logic       card_parity_err,
   input  wire logic       legacy_auto_pwr_bit,
   input  wire logic       legacy_mode,
   input  wire logic       mf_central_dma,
   input  wire logic       ring_in,
   input  wire logic       pme_in,
   input  wire logic [3:0] card_addr_hi,
   output logic            rsvd_pin_oe_n,
   output logic [3:0]      upper_card_address_pins_out,
   output logic            upper_card_address_pins_oe_n,
   output logic            card_dma_request_line,
   output logic [2:0]      dma_chan,
   output logic            dma_chan_wide,
   output logic            ring_indicate_out,
   output logic [9:0]      ctl
);
   logic [cbsc_pkg::CFG_W-1:0] c;
   assign c = cfg_if.cfg;

   function automatic logic chan_used(input logic [2:0] ch);
      return ch != cbsc_pkg::CHAN_NONE;
   endfunction

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rsvd_pin_oe_n                <= 1'b1;
         upper_card_address_pins_out  <= 4'h0;
         upper_card_address_pins_oe_n <= 1'b1;
         card_dma_request_line        <= 1'b0;
         dma_chan                     <= cbsc_pkg::CHAN_NONE;
         dma_chan_wide                <= 1'b0;
         ring_indicate_out            <= 1'b0;
         ctl                          <= 10'h000;
      end else begin
         rsvd_pin_oe_n <= !(card32_present & c[cbsc_pkg::B_RSVDPIN]);
         upper_card_address_pins_out  <= card_addr_hi;
         upper_card_address_pins_oe_n <= !card16_present |
                                         c[cbsc_pkg::B_REDVID];
         card_dma_request_line <= c[cbsc_pkg::B_DREQEN] & card16_present &
            card_card_dma_request_line &
            chan_used(c[cbsc_pkg::B_CHAN_HI:cbsc_pkg::B_CHAN_LO]);
         dma_chan      <= c[cbsc_pkg::B_CHAN_HI:cbsc_pkg::B_CHAN_LO];
         dma_chan_wide <=
            chan_used(c[cbsc_pkg::B_CHAN_HI:cbsc_pkg::B_CHAN_LO]) &
            c[cbsc_pkg::B_CHAN_HI];
         // Ring takes the pin over a pending wake when both are shared.
         ring_indicate_out <= c[cbsc_pkg::B_RING_WAKE_PIN_MUX] ? pme_in
                              : (ring_in | pme_in);
         ctl[0] <= !c[cbsc_pkg::B_GUARD];
         ctl[1] <= c[cbsc_pkg::B_BURSTDN];
         ctl[2] <= c[cbsc_pkg::B_BURSTUP];
         ctl[3] <= c[cbsc_pkg::B_AUTOPWR] & legacy_auto_pwr_bit;
         ctl[4] <= !(c[cbsc_pkg::B_IDLECLK] & card32_present & card_idle &
                     card_clk_stopped);
         ctl[5] <= !c[cbsc_pkg::B_IDRW];
         ctl[6] <= c[cbsc_pkg::B_PARITY] & card32_present &
                   card_parity_err;
         ctl[7] <= c[cbsc_pkg::B_CDMA] & mf_central_dma;
         ctl[8] <= legacy_mode & !c[cbsc_pkg::B_SUPPLY];
         ctl[9] <= legacy_mode & c[cbsc_pkg::B_SUPPLY];
      end
   end

   a_ring_priority: assert property (
      @(posedge mclk) disable iff (!rst_n)
      !c[cbsc_pkg::B_RING_WAKE_PIN_MUX] && ring_in && $stable(c) |=> ring_indicate_out)
      else $error("ring indicate lost its priority on the shared pin");
endmodule // cbsc_pin_ctl

// file: cbsc_pkg.sv
// Shared constants and types for the card bridge system control block.
package cbsc_pkg;
   localparam int unsigned ADDR_W   = 8;
   localparam int unsigned DATA_W   = 32;
   localparam int unsigned CFG_W    = 25;
   localparam logic [7:0]  SYSCTL_ADDR = 8'h80;

   // Bit positions inside the system control register.
   localparam int unsigned B_FLAG     = 25;
   localparam int unsigned B_MODE     = 24;
   localparam int unsigned B_ZERO     = 23;
   localparam int unsigned B_RSVDPIN  = 22;
   localparam int unsigned B_GUARD    = 21;
   localparam int unsigned B_REDVID   = 20;
   localparam int unsigned B_DREQEN   = 19;
   localparam int unsigned B_CHAN_HI  = 18;
   localparam int unsigned B_CHAN_LO  = 16;
   localparam int unsigned B_BURSTDN  = 15;
   localparam int unsigned B_BURSTUP  = 14;
   localparam int unsigned B_ACT      = 13;
   localparam int unsigned B_ONE      = 12;
   localparam int unsigned B_STREAM   = 11;
   localparam int unsigned B_UPDLY    = 10;
   localparam int unsigned B_DNDLY    = 9;
   localparam int unsigned B_PROBE    = 8;
   localparam int unsigned B_AUTOPWR  = 7;
   localparam int unsigned B_IDLECLK  = 6;
   localparam int unsigned B_IDRW     = 5;
   localparam int unsigned B_PARITY   = 4;
   localparam int unsigned B_CDMA     = 3;
   localparam int unsigned B_SUPPLY   = 2;
   localparam int unsigned B_HOLD_CLOCKS_RUNNING  = 1;
   localparam int unsigned B_RING_WAKE_PIN_MUX    = 0;

   localparam logic [CFG_W-1:0] RW_MASK   = 25'h17fc0ff;
   localparam logic [CFG_W-1:0] CFG_RESET = 25'h0448060;
   localparam logic [2:0]       CHAN_NONE = 3'h4;

   // Power switch serial stream timing.
   localparam int unsigned CLK_NS        = 100;
   localparam int unsigned STREAM_BITS   = 8;
   localparam int unsigned BIT_NS        = 1000;
   localparam int unsigned UP_SETTLE_NS  = 300000;
   localparam int unsigned DN_SETTLE_NS  = 100000;
   localparam int unsigned BIT_CYC = (BIT_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned UP_CYC  = (UP_SETTLE_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned DN_CYC  = (DN_SETTLE_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned CNT_W   = 12;

   typedef enum logic [1:0] {
      PS_IDLE   = 2'b00,
      PS_SHIFT  = 2'b01,
      PS_SETTLE = 2'b10
   } cbsc_pwr_state_e;
endpackage

// file: cbsc_pwr_seq.sv
// Serial power switch stream and settling delay sequencer.
`timescale 1ns/1ps
module cbsc_pwr_seq (
   input  wire logic       mclk,
   input  wire logic       rst_n,
   input  wire logic       start,
   input  wire logic       power_up,
   input  wire logic [7:0] word,
   output logic            sw_clk,
   output logic            sw_data,
   output logic            sw_latch,
   output logic            stream_busy,
   output logic            up_busy,
   output logic            down_busy
);
   cbsc_pkg::cbsc_pwr_state_e   state_q;
   logic [cbsc_pkg::CNT_W-1:0]  cnt_q;
   logic [2:0]                  bit_q;
   logic [7:0]                  sh_q;
   logic                        up_q;
   logic                        last_bit;

   assign last_bit = (cnt_q == '0) &&
                     (bit_q == 3'(cbsc_pkg::STREAM_BITS - 1));

   // A request that arrives while busy is dropped; software polls busy.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         state_q <= cbsc_pkg::PS_IDLE;
         cnt_q   <= '0;
         bit_q   <= '0;
         sh_q    <= '0;
         up_q    <= 1'b0;
      end else begin
         unique case (state_q)
            cbsc_pkg::PS_IDLE: begin
               if (start) begin
                  state_q <= cbsc_pkg::PS_SHIFT;
                  cnt_q   <= cbsc_pkg::CNT_W'(cbsc_pkg::BIT_CYC - 1);
                  bit_q   <= '0;
                  sh_q    <= word;
                  up_q    <= power_up;
               end
            end
            cbsc_pkg::PS_SHIFT: begin
               if (last_bit) begin
                  state_q <= cbsc_pkg::PS_SETTLE;
                  cnt_q   <= up_q ? cbsc_pkg::CNT_W'(cbsc_pkg::UP_CYC - 1)
                                  : cbsc_pkg::CNT_W'(cbsc_pkg::DN_CYC - 1);
               end else if (cnt_q == '0) begin
                  cnt_q <= cbsc_pkg::CNT_W'(cbsc_pkg::BIT_CYC - 1);
                  bit_q <= bit_q + 3'h1;
                  sh_q  <= {sh_q[6:0], 1'b0};
               end else begin
                  cnt_q <= cnt_q - 1'b1;
               end
            end
            cbsc_pkg::PS_SETTLE: begin
               if (cnt_q == '0) begin
                  state_q <= cbsc_pkg::PS_IDLE;
               end else begin
                  cnt_q <= cnt_q - 1'b1;
               end
            end
            default: state_q <= cbsc_pkg::PS_IDLE;
         endcase
      end
   end

   assign sw_data     = (state_q == cbsc_pkg::PS_SHIFT) & sh_q[7];
   assign sw_clk      = (state_q == cbsc_pkg::PS_SHIFT) & (cnt_q == '0);
   assign sw_latch    = (state_q == cbsc_pkg::PS_SHIFT) & last_bit;
   assign stream_busy = (state_q != cbsc_pkg::PS_IDLE);
   assign up_busy     = (state_q == cbsc_pkg::PS_SETTLE) & up_q;
   assign down_busy   = (state_q == cbsc_pkg::PS_SETTLE) & !up_q;
endmodule // cbsc_pwr_seq

// file: cbsc_sysctl.sv
// System control register bank of the card bridge, with status and pin control.
`timescale 1ns/1ps
// Behaviour
// - Mode bit 24 set: socket power write raises a management interrupt pulse.
// - Flag bit 25 sets on that event; writing one clears it.
// - Bit 23 reads zero, bit 12 reads one, writes ignored.
// - Bit 22 with 32-bit card drives reserved pins low, else float.
// - Bit 21 clear enables supply guard for 16-bit cards.
// - Bit 20 floats upper card address pins for 16-bit cards.
// - Bit 19 forwards 16-bit card DMA requests, else ignored.
// - Channel field: 0-3 narrow, 5-7 wide, 4 unused and reset.
// - Bit 15 allows downstream read bursts, reset enabled.
// - Bit 14 allows upstream read bursts, reset disabled.
// - Bit 13 sets on card access, clears when read.
// - Bit 11 busy while power stream is sent and its delay runs.
// - Bit 10 busy during power-up settling after a stream.
// - Bit 9 busy during power-down settling after a stream.
// - Bit 8 shows card interrogation in progress.
// - Bit 7 gates the legacy automatic power switch enable.
// - Bit 6 stops idle 32-bit card state machine clock.
// - Bit 5 clear makes identification registers writable.
// - Bit 4 reports 32-bit card parity errors on system error.
// - Bit 3 enables central DMA when pins are set for it.
// - Bit 2 picks 5 V, clear picks 3.3 V, in legacy mode.
// - Bit 1 keeps both clocks from being stopped.
// - Bit 0 clear shares pin, ring first; set routes wake only.
module cbsc_sysctl (
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic [7:0]  bus_addr,
   input  wire logic [31:0] bus_wdata,
   input  wire logic        bus_wr,
   input  wire logic        bus_rd,
   output logic [31:0]      bus_rdata,
   input  wire logic        sock_pwr_wr,
   input  wire logic        sock_pwr_up,
   input  wire logic [7:0]  sock_pwr_word,
   input  wire logic        card_access,
   input  wire logic        card_probe_active,
   input  wire logic        card32_present,
   input  wire logic        card16_present,
   input  wire logic        card_idle,
   input  wire logic        card_clk_stopped,
   input  wire logic        card_card_dma_request_line,
   input  wire logic        card_parity_err,
   input  wire logic        legacy_auto_pwr_bit,
   input  wire logic        legacy_mode,
   input  wire logic        mf_central_dma,
   input  wire logic        ring_in,
   input  wire logic        pme_in,
   input  wire logic [3:0]  card_addr_hi,
   output logic            mgmt_irq,
   output logic            pwr_sw_clk,
   output logic            pwr_sw_data,
   output logic            pwr_sw_latch,
   output logic            rsvd_pin_out,
   output logic            rsvd_pin_oe_n,
   output logic [3:0]      upper_card_address_pins_out,
   output logic            upper_card_address_pins_oe_n,
   output logic            card_dma_request_line,
   output logic [2:0]      dma_chan,
   output logic            dma_chan_wide,
   output logic            ring_indicate_out,
   output logic            supply_guard_en,
   output logic            burst_dn_en,
   output logic            burst_up_en,
   output logic            auto_power_switch_en,
   output logic            cb_sm_clk_en,
   output logic            id_regs_writable,
   output logic            syserr_req,
   output logic            central_dma_en,
   output logic            vcc33_en,
   output logic            vcc5_en,
   output logic            hold_clocks_running
);
   logic [cbsc_pkg::CFG_W-1:0] cfg_q;
   logic [cbsc_pkg::CFG_W-1:0] cfg_d;
   logic                       flag_q;
   logic                       act_q;
   logic                       probe_q;
   logic                       irq_q;
   logic [31:0]                rdata_q;
   logic [31:0]                rd_val;
   logic                       hit;
   logic                       wr_hit;
   logic                       rd_hit;
   logic                       irq_event;
   logic                       stream_busy;
   logic                       up_busy;
   logic                       down_busy;
   logic [9:0]                 ctl;

   cbsc_cfg_if cfg_bus ();

   assign hit       = (bus_addr == cbsc_pkg::SYSCTL_ADDR);
   assign wr_hit    = bus_wr & hit;
   assign rd_hit    = bus_rd & hit;
   assign irq_event = sock_pwr_wr & cfg_q[cbsc_pkg::B_MODE];

   // Only writable positions take bus data; status positions are not stored.
   assign cfg_d = (bus_wdata[cbsc_pkg::CFG_W-1:0] & cbsc_pkg::RW_MASK) |
                  (cfg_q & ~cbsc_pkg::RW_MASK);

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         cfg_q <= cbsc_pkg::CFG_RESET;
      end else if (wr_hit) begin
         cfg_q <= cfg_d;
      end
   end

   // The event wins over a clearing write in the same cycle.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         flag_q <= 1'b0;
      end else if (irq_event) begin
         flag_q <= 1'b1;
      end else if (wr_hit && bus_wdata[cbsc_pkg::B_FLAG]) begin
         flag_q <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= irq_event;
      end
   end

   // An access seen in the cycle of the clearing read stays set for next time.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         act_q <= 1'b0;
      end else if (card_access) begin
         act_q <= 1'b1;
      end else if (rd_hit) begin
         act_q <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         probe_q <= 1'b0;
      end else begin
         probe_q <= card_probe_active;
      end
   end

   always_comb begin
      rd_val = 32'h0000_0000;
      rd_val[cbsc_pkg::CFG_W-1:0] = cfg_q & cbsc_pkg::RW_MASK;
      rd_val[cbsc_pkg::B_FLAG]   = flag_q;
      rd_val[cbsc_pkg::B_ZERO]   = 1'b0;
      rd_val[cbsc_pkg::B_ONE]    = 1'b1;
      rd_val[cbsc_pkg::B_ACT]    = act_q;
      rd_val[cbsc_pkg::B_STREAM] = stream_busy;
      rd_val[cbsc_pkg::B_UPDLY]  = up_busy;
      rd_val[cbsc_pkg::B_DNDLY]  = down_busy;
      rd_val[cbsc_pkg::B_PROBE]  = probe_q;
   end

   // Read data stand for one cycle only; unmapped reads return zero.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rdata_q <= 32'h0000_0000;
      end else if (rd_hit) begin
         rdata_q <= rd_val;
      end else begin
         rdata_q <= 32'h0000_0000;
      end
   end

   assign bus_rdata = rdata_q;
   assign mgmt_irq  = irq_q;

   assign cfg_bus.cfg = cfg_q;

   cbsc_pwr_seq u_pwr (
      .mclk        (mclk),
      .rst_n       (rst_n),
      .start       (sock_pwr_wr),
      .power_up    (sock_pwr_up),
      .word        (sock_pwr_word),
      .sw_clk      (pwr_sw_clk),
      .sw_data     (pwr_sw_data),
      .sw_latch    (pwr_sw_latch),
      .stream_busy (stream_busy),
      .up_busy     (up_busy),
      .down_busy   (down_busy)
   );

   cbsc_pin_ctl u_pins (
      .mclk                         (mclk),
      .rst_n                        (rst_n),
      .cfg_if                       (cfg_bus),
      .card32_present               (card32_present),
      .card16_present               (card16_present),
      .card_idle                    (card_idle),
      .card_clk_stopped             (card_clk_stopped),
      .card_card_dma_request_line                    (card_card_dma_request_line),
      .card_parity_err              (card_parity_err),
      .legacy_auto_pwr_bit          (legacy_auto_pwr_bit),
      .legacy_mode                  (legacy_mode),
      .mf_central_dma               (mf_central_dma),
      .ring_in                      (ring_in),
      .pme_in                       (pme_in),
      .card_addr_hi                 (card_addr_hi),
      .rsvd_pin_oe_n                (rsvd_pin_oe_n),
      .upper_card_address_pins_out  (upper_card_address_pins_out),
      .upper_card_address_pins_oe_n (upper_card_address_pins_oe_n),
      .card_dma_request_line        (card_dma_request_line),
      .dma_chan                     (dma_chan),
      .dma_chan_wide                (dma_chan_wide),
      .ring_indicate_out            (ring_indicate_out),
      .ctl                          (ctl)
   );

   // The reserved terminals are only ever pulled low, never driven high.
   assign rsvd_pin_out         = 1'b0;
   assign supply_guard_en      = ctl[0];
   assign burst_dn_en          = ctl[1];
   assign burst_up_en          = ctl[2];
   assign auto_power_switch_en = ctl[3];
   assign cb_sm_clk_en         = ctl[4];
   assign id_regs_writable     = ctl[5];
   assign syserr_req           = ctl[6];
   assign central_dma_en       = ctl[7];
   assign vcc33_en             = ctl[8];
   assign vcc5_en              = ctl[9];
   // Combinational so a clock stop request is refused in the same cycle.
   assign hold_clocks_running  = cfg_q[cbsc_pkg::B_HOLD_CLOCKS_RUNNING];

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   a_irq_event_pulse: assert property (
      sock_pwr_wr && cfg_q[cbsc_pkg::B_MODE] |=> mgmt_irq ##1
         (!mgmt_irq || $past(irq_event)))
      else $error("management interrupt pulse missing or too long");

   a_irq_disabled: assert property (
      !(sock_pwr_wr && cfg_q[cbsc_pkg::B_MODE]) |=> !mgmt_irq)
      else $error("management interrupt without an enabled power write");

   a_flag_set_clear: assert property (
      wr_hit && bus_wdata[cbsc_pkg::B_FLAG] && !irq_event |=> !flag_q)
      else $error("interrupt flag not cleared by a one written");

   a_flag_sticky: assert property (
      irq_event |=> flag_q)
      else $error("interrupt flag missed a power write event");

   a_fixed_bits: assert property (
      rd_hit |=> bus_rdata[cbsc_pkg::B_ZERO] == 1'b0 &&
                 bus_rdata[cbsc_pkg::B_ONE] == 1'b1)
      else $error("reserved bits read back wrong");

   a_unmapped_zero: assert property (
      bus_rd && !hit |=> bus_rdata == 32'h0000_0000)
      else $error("unmapped read returned data");

   a_rdata_one_cycle: assert property (
      !bus_rd |=> bus_rdata == 32'h0000_0000)
      else $error("read data held beyond its cycle");

   a_write_store: assert property (
      wr_hit |=> (bus_rdata == 32'h0000_0000) &&
                 cfg_q == $past(cfg_d))
      else $error("write did not update the writable fields");

   a_activity_read: assert property (
      card_access ##1 (rd_hit && !card_access)
      |=> bus_rdata[cbsc_pkg::B_ACT] && !act_q)
      else $error("socket activity not reported or not cleared by read");

   a_stream_start: assert property (
      sock_pwr_wr && !stream_busy |=> stream_busy [*8])
      else $error("power stream busy not held while streaming");

   a_settle_split: assert property (
      !(up_busy && down_busy) && (!(up_busy || down_busy) || stream_busy))
      else $error("settle flags inconsistent with stream busy");

   a_reset_values: assert property (
      $rose(rst_n) |-> cfg_q == cbsc_pkg::CFG_RESET &&
                       !mgmt_irq && !flag_q && !act_q)
      else $error("register not at its reset value");
endmodule // cbsc_sysctl

// file: cbsc_tb.sv
// Self-checking testbench for the card bridge system control register.
`timescale 1ns/1ps
module testbench;
   logic        mclk = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  bus_addr = 8'h80;
   logic [31:0] bus_wdata = 32'h0;
   logic        bus_wr = 1'b0;
   logic        bus_rd = 1'b0;
   logic [7:0]  sock_pwr_word = 8'ha5;
   logic [3:0]  card_addr_hi = 4'h9;
   logic        sock_pwr_wr = 1'b0, sock_pwr_up = 1'b0, card_access = 1'b0;
   logic        card_probe_active = 1'b0, card32_present = 1'b1;
   logic        card16_present = 1'b1, card_idle = 1'b1, card_card_dma_request_line = 1'b1;
   logic        card_clk_stopped = 1'b1, card_parity_err = 1'b1;
   logic        legacy_auto_pwr_bit = 1'b1, legacy_mode = 1'b1;
   logic        mf_central_dma = 1'b1, ring_in = 1'b1, pme_in = 1'b0;
   logic [31:0] bus_rdata;
   logic [3:0]  upper_card_address_pins_out;
   logic [2:0]  dma_chan;
   logic        mgmt_irq, pwr_sw_clk, pwr_sw_data, pwr_sw_latch, rsvd_pin_out;
   logic        rsvd_pin_oe_n, upper_card_address_pins_oe_n, dma_chan_wide;
   logic        card_dma_request_line, ring_indicate_out, supply_guard_en;
   logic        burst_dn_en, burst_up_en, auto_power_switch_en, cb_sm_clk_en;
   logic        id_regs_writable, syserr_req, central_dma_en, vcc33_en;
   logic        vcc5_en, hold_clocks_running;
   logic [31:0] v;
   int          mismatches = 0;
   int          compares = 0;
   int          sw_clks = 0;
   int          sw_latches = 0;
   logic [7:0]  sw_bits = 8'h00;
   wire  [20:0] pins = {rsvd_pin_oe_n, upper_card_address_pins_oe_n,
      card_dma_request_line, dma_chan_wide, ring_indicate_out,
      supply_guard_en, burst_dn_en, burst_up_en, auto_power_switch_en,
      cb_sm_clk_en, id_regs_writable, syserr_req, central_dma_en, vcc33_en,
      vcc5_en, hold_clocks_running, rsvd_pin_out, upper_card_address_pins_out};

   cbsc_sysctl u_dut (.*);

   always #50 mclk = ~mclk;

   // The switch outputs are combinational, so they are read mid-cycle.
   always @(negedge mclk) begin
      if (pwr_sw_clk === 1'b1) begin
         sw_clks++;
         sw_bits = {sw_bits[6:0], pwr_sw_data};
      end
      if (pwr_sw_latch === 1'b1) begin
         sw_latches++;
      end
   end

   task automatic chk(input string n, input logic [31:0] e,
                      input logic [31:0] g);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic report_and_stop();
      $display("mismatches %0d compares %0d", mismatches, compares);
      if (mismatches == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Waits past the write so the registered pin outputs have settled too.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      bus_wr <= 1'b1;
      bus_addr <= a;
      bus_wdata <= d;
      @(posedge mclk);
      bus_wr <= 1'b0;
      @(posedge mclk);
      @(negedge mclk);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge mclk);
      bus_rd <= 1'b1;
      bus_addr <= a;
      @(posedge mclk);
      bus_rd <= 1'b0;
      @(negedge mclk);
      d = bus_rdata;
   endtask

   task automatic t_fields();
      rd(8'h80, v);
      chk("reset value", 32'h00449060, v);
      wr(8'h80, 32'hffffffff);
      rd(8'h80, v);
      chk("all ones", 32'h017fd0ff, v);
      chk("pins ones", 32'h000e7369, {11'h0, pins});
      wr(8'h84, 32'h0);
      rd(8'h84, v);
      chk("unmapped", 32'h0, v);
      rd(8'h80, v);
      chk("kept", 32'h017fd0ff, v);
      @(posedge mclk);
      card16_present <= 1'b0;
      card32_present <= 1'b0;
      legacy_mode <= 1'b0;
      mf_central_dma <= 1'b0;
      card_parity_err <= 1'b0;
      card_addr_hi <= 4'h6;
      ring_in <= 1'b0;
      pme_in <= 1'b1;
      wr(8'h80, 32'h0);
      rd(8'h80, v);
      chk("all zero", 32'h00001000, v);
      chk("pins zero", 32'h00198c06, {11'h0, pins});
   endtask

   task automatic t_status();
      @(posedge mclk);
      card_access <= 1'b1;
      card_probe_active <= 1'b1;
      @(posedge mclk);
      card_access <= 1'b0;
      bus_rd <= 1'b1;
      bus_addr <= 8'h80;
      @(posedge mclk);
      bus_rd <= 1'b0;
      @(negedge mclk);
      v = bus_rdata;
      chk("activity", 32'h00003100, v);
      rd(8'h80, v);
      chk("read clears", 32'h00001100, v);
      @(posedge mclk);
      card_probe_active <= 1'b0;
      rd(8'h80, v);
      chk("probe done", 32'h00001000, v);
   endtask

   task automatic t_chan();
      @(posedge mclk);
      card16_present <= 1'b1;
      for (int c = 0; c < 8; c++) begin
         wr(8'h80, 32'h00080000 | (c << 16));
         chk("dma pins", {27'h0, c[2:0] != 3'h4, c[2:0] >= 3'h5, c[2:0]},
             {27'h0, card_dma_request_line, dma_chan_wide, dma_chan});
      end
   endtask

   // Polling reads also clear activity, which is harmless here.
   task automatic t_power(input logic up, input logic irq);
      int   n;
      int   clk0;
      int   lat0;
      logic seen;
      wr(8'h80, {7'h0, irq, 24'h0});
      clk0 = sw_clks;
      lat0 = sw_latches;
      @(posedge mclk);
      sock_pwr_wr <= 1'b1;
      sock_pwr_up <= up;
      @(posedge mclk);
      sock_pwr_wr <= 1'b0;
      @(negedge mclk);
      chk("irq pulse", {31'h0, irq}, {31'h0, mgmt_irq});
      rd(8'h80, v);
      chk("stream start", {6'h0, irq, irq, 24'h1800}, v);
      seen = 1'b0;
      n = 0;
      while (v[11] === 1'b1 && n < 2000) begin
         rd(8'h80, v);
         if (v[up ? 10 : 9] === 1'b1) seen = 1'b1;
         n++;
      end
      if (n >= 2000) begin
         mismatches++;
         report_and_stop();
      end
      chk("settle flag", 32'h1, {31'h0, seen});
      chk("stream clocks", 32'd8, 32'(sw_clks - clk0));
      chk("stream latch", 32'd1, 32'(sw_latches - lat0));
      chk("stream word", 32'h000000a5, {24'h0, sw_bits});
      chk("settle long", 32'h1,
          {31'h0, n * 2 >= (up ? cbsc_pkg::UP_CYC : cbsc_pkg::DN_CYC)});
      wr(8'h80, 32'h02000000);
      rd(8'h80, v);
      chk("flag clear", 32'h00001000, v);
   endtask

   initial begin
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      t_fields();
      t_status();
      t_chan();
      t_power(1'b0, 1'b1);
      t_power(1'b1, 1'b0);
      report_and_stop();
   end
endmodule // testbench
